// ### shared/gba_pkg.sv
package gba_pkg;
  // Configuration index of each register
  localparam logic [7:0] OFS_HOST_OPT = 8'h87;
  localparam logic [7:0] OFS_ARB_OPT = 8'h88;
  localparam logic [7:0] OFS_GFX_SLICE = 8'h89;
  localparam logic [7:0] OFS_CPU_SLICE = 8'h8a;
  localparam logic [7:0] OFS_RETRY = 8'h8b;
  localparam logic [7:0] OFS_MEM_OPT = 8'h8c;
  localparam logic [7:0] OFS_RSVD_8D = 8'h8d;
  localparam logic [7:0] OFS_PORT_SLICE = 8'h8e;
  localparam logic [7:0] OFS_PRIM_SLICE = 8'h8f;
  localparam logic [7:0] OFS_CAP_ID = 8'he0;
  localparam logic [7:0] OFS_CAP_NEXT = 8'he1;
  localparam logic [7:0] OFS_CAP_LO = 8'he2;
  localparam logic [7:0] OFS_CAP_HI = 8'he3;
  // Reset values
  localparam logic [7:0] RST_OPT = 8'h00;
  localparam logic [7:0] RST_SLICE = 8'h20;
  localparam logic [7:0] RST_CAP_ID = 8'h01;
  localparam logic [7:0] RST_CAP_NEXT = 8'h00;
  localparam logic [15:0] RST_CAPS = 16'h0000;
  // Writable bits; all others are reserved and read zero
  localparam logic [7:0] WM_HOST_OPT = 8'h60;
  localparam logic [7:0] WM_ARB_OPT = 8'h8c;
  localparam logic [7:0] WM_RETRY = 8'h0f;
  localparam logic [7:0] WM_MEM_OPT = 8'h83;
  localparam logic [15:0] WM_CAPS = 16'hfe3f;
  // Field positions
  localparam int B_MONO_EN = 6;
  localparam int B_NB_FRAME_OFF = 5;
  localparam int B_FLUSH_MODE = 7;
  localparam int B_FORCE_FLUSH = 3;
  localparam int B_FORCE_HOST_REQ = 2;
  localparam int B_MRM_OFF = 7;
  localparam int B_UNLOCK = 5;
  localparam int B_AUX_POWER = 4;
  localparam int B_WAKE_D3COLD = 15;
  // Retry field codes and wait thresholds
  localparam logic [1:0] RETRY_LONG = 2'b00;
  localparam logic [1:0] RETRY_MID = 2'b01;
  localparam logic [1:0] RETRY_PSEUDO = 2'b10;
  localparam logic [1:0] RETRY_NEVER = 2'b11;
  localparam logic [5:0] WAIT_LONG_FIRST = 6'h20;
  localparam logic [5:0] WAIT_LONG_NEXT = 6'h08;
  localparam logic [5:0] WAIT_MID_FIRST = 6'h10;
  localparam logic [5:0] WAIT_MID_NEXT = 6'h04;
  localparam logic [5:0] WAIT_PSEUDO = 6'h02;
  // Prefetch limit codes
  localparam logic [1:0] PREF_TWO = 2'b01;
  localparam logic [1:0] PREF_THREE = 2'b10;
  // Legacy video decode constants
  localparam logic [14:0] LEGACY_MEM_TAG = 15'h0005;
  localparam logic [16:0] MONO_MEM_TAG = 17'h00016;
  localparam logic [3:0] PROG_SIZE_MAX = 4'h4;
  // Arbiter states
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_FLUSH = 3'b010,
    ARB_OWN = 3'b100
  } gba_arb_t;
endpackage

// ### hw/gba_graphics_arbiter.sv
// How it works
// - Fixed window enable posts legacy frame writes
// - Programmable window enable decodes base/size, posts
// - Mono plus routing sends mono ranges primary
// - Non-buffered frame control bit is active low
// - Retried reader marked, flushed before next graphics grant
// - Forced mode flushes before every graphics grant
// - Force option holds own bus request
// - Graphics master gets its minimum slice
// - CPU gets its minimum slice
// - Port read/write master gets minimum slice
// - Primary write traffic gets minimum slice
// - Slice counts after grant and idle bus
// - Slice low two bits ignored in the count, read back as written
// - Primary-bound retry threshold by code
// - Host-bound retry threshold, same codes
// - Read-multiple recognised when bit is zero
// - Prefetch limit two or three lines
// - Capability identifier reads 01h
// - Next pointer reads 00h, list ends
// - Power registers writable only when unlocked
// - Five wake-capable state bits, D0 upward
// - Sleep level support and init flags
// - Aux power meaningful only with D3cold wake
// - Routing enable sends legacy video to graphics
// - Window base bits 31:20, size codes
module gba_graphics_arbiter
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] cfgAddr,
  input wire logic cfgWrEn,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgRdEn,
  output logic [7:0] cfgRdData,
  input wire logic unlockCtrl,
  input wire logic videoRouteEn,
  input wire logic fixedWindowEn,
  input wire logic progWindowEn,
  input wire logic [15:0] programmableVideoWindow,
  input wire logic hostMemValid,
  input wire logic hostMemWrite,
  input wire logic [31:0] hostMemAddr,
  input wire logic hostIoValid,
  input wire logic [15:0] hostIoAddr,
  output logic postHostWrite,
  output logic memToGraphics,
  output logic memToPrimary,
  output logic ioToGraphics,
  output logic ioToPrimary,
  input wire logic [3:0] busReq,
  input wire logic busIdle,
  input wire logic gfxReadRetried,
  input wire logic flushDone,
  input wire logic hostWritePending,
  output logic [3:0] busGrant,
  output logic flushReq,
  output logic hostBusRequest,
  input wire logic retryToHost,
  input wire logic retryFirstPhase,
  input wire logic [5:0] retryWaitClocks,
  output logic retryNow,
  output logic mrmRecognize,
  output logic [1:0] prefetchLines,
  output logic nbFrameCtrlEn,
  output logic auxPowerNeeded
);
  import gba_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Slice length in clocks with the two low bits dropped
  function automatic logic [7:0] sliceClocks(input logic [7:0] slice);
    sliceClocks = {slice[7:2], 2'b00};
  endfunction
  // Wait clocks beyond which a cycle is retried; NEVER gives no threshold
  function automatic logic retryDue(input logic [1:0] code, input logic first,
                                    input logic [5:0] wait_);
    logic [5:0] lim;
    lim = 6'h00;
    unique case (code)
      RETRY_LONG: lim = first ? WAIT_LONG_FIRST : WAIT_LONG_NEXT;
      RETRY_MID: lim = first ? WAIT_MID_FIRST : WAIT_MID_NEXT;
      RETRY_PSEUDO: lim = WAIT_PSEUDO;
      RETRY_NEVER: lim = 6'h00;
    endcase
    retryDue = (code != RETRY_NEVER) && (wait_ > lim);
  endfunction
  // Rotating pick: first requester after the last owner
  function automatic logic [1:0] pickNext(input logic [3:0] req, input logic [1:0] last);
    logic [1:0] idx;
    logic found;
    pickNext = last;
    found = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      idx = 2'(last + 2'(i));
      if (!found && req[idx]) begin
        pickNext = idx;
        found = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] hostOpt; // Mono enable, frame request control
  logic [7:0] arbOpt; // Flush modes, forced request
  logic [7:0] gfxSlice, cpuSlice, portSlice, primSlice; // All 8 bits kept, low 2 unused
  logic [7:0] retryCtl; // [3:2] primary-bound, [1:0] host-bound
  logic [7:0] memOpt; // Read-multiple off, prefetch limit
  logic [7:0] capId, capNext; // Capability header bytes
  logic [15:0] capRegs; // Wake states, sleep support, init, aux power
  logic pmWrOk; // Write strobe qualified by the bridge unlock
  assign pmWrOk = cfgWrEn && unlockCtrl;

  // Option and slice registers; reserved bits masked off on write
  always_ff @(posedge clk) begin
    if (srst) begin
      hostOpt <= RST_OPT;
      arbOpt <= RST_OPT;
      gfxSlice <= RST_SLICE;
      cpuSlice <= RST_SLICE;
      retryCtl <= RST_OPT;
      memOpt <= RST_OPT;
      portSlice <= RST_SLICE;
      primSlice <= RST_SLICE;
    end else if (cfgWrEn) begin
      unique case (cfgAddr)
        OFS_HOST_OPT: hostOpt <= cfgWrData & WM_HOST_OPT;
        OFS_ARB_OPT: arbOpt <= cfgWrData & WM_ARB_OPT;
        OFS_GFX_SLICE: gfxSlice <= cfgWrData;
        OFS_CPU_SLICE: cpuSlice <= cfgWrData;
        OFS_RETRY: retryCtl <= cfgWrData & WM_RETRY;
        OFS_MEM_OPT: memOpt <= cfgWrData & WM_MEM_OPT;
        OFS_PORT_SLICE: portSlice <= cfgWrData;
        OFS_PRIM_SLICE: primSlice <= cfgWrData;
        default: ; // Reserved and foreign indices ignore writes
      endcase
    end
  end

  // Power capability block: read-only unless the main bridge unlocks it
  always_ff @(posedge clk) begin
    if (srst) begin
      capId <= RST_CAP_ID;
      capNext <= RST_CAP_NEXT;
      capRegs <= RST_CAPS;
    end else if (pmWrOk) begin
      unique case (cfgAddr)
        OFS_CAP_ID: capId <= cfgWrData;
        OFS_CAP_NEXT: capNext <= cfgWrData;
        OFS_CAP_LO: capRegs[7:0] <= cfgWrData & WM_CAPS[7:0];
        OFS_CAP_HI: capRegs[15:8] <= cfgWrData & WM_CAPS[15:8];
        default: ;
      endcase
    end
  end

  // Read data lands one clock after the read strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      cfgRdData <= 8'h00;
    end else if (cfgRdEn) begin
      unique case (cfgAddr)
        OFS_HOST_OPT: cfgRdData <= hostOpt;
        OFS_ARB_OPT: cfgRdData <= arbOpt;
        OFS_GFX_SLICE: cfgRdData <= gfxSlice;
        OFS_CPU_SLICE: cfgRdData <= cpuSlice;
        OFS_RETRY: cfgRdData <= retryCtl;
        OFS_MEM_OPT: cfgRdData <= memOpt;
        OFS_PORT_SLICE: cfgRdData <= portSlice;
        OFS_PRIM_SLICE: cfgRdData <= primSlice;
        OFS_CAP_ID: cfgRdData <= capId;
        OFS_CAP_NEXT: cfgRdData <= capNext;
        OFS_CAP_LO: cfgRdData <= capRegs[7:0];
        OFS_CAP_HI: cfgRdData <= capRegs[15:8];
        default: cfgRdData <= 8'h00;
      endcase
    end else begin
      cfgRdData <= 8'h00;
    end
  end

  // Decoded option outputs, registered so they are glitch free
  always_ff @(posedge clk) begin
    if (srst) begin
      mrmRecognize <= 1'b1;
      prefetchLines <= 2'd2;
      nbFrameCtrlEn <= 1'b1;
      auxPowerNeeded <= 1'b0;
    end else begin
      mrmRecognize <= !memOpt[B_MRM_OFF];
      // Reserved prefetch codes fall back to the safer two-line limit
      prefetchLines <= (memOpt[1:0] == PREF_THREE) ? 2'd3 : 2'd2;
      nbFrameCtrlEn <= !hostOpt[B_NB_FRAME_OFF];
      auxPowerNeeded <= capRegs[B_AUX_POWER] && capRegs[B_WAKE_D3COLD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle address decode
  logic legacyMem, monoMem, monoIo, videoIo, progHit, monoOn; // Per-cycle range hits
  logic [11:0] progMask; // Address bits below the window size
  assign legacyMem = hostMemAddr[31:17] == LEGACY_MEM_TAG;
  assign monoMem = hostMemAddr[31:15] == MONO_MEM_TAG;
  assign monoIo = (hostIoAddr == 16'h03b4) || (hostIoAddr == 16'h03b5) ||
                  (hostIoAddr == 16'h03b8) || (hostIoAddr == 16'h03b9) ||
                  (hostIoAddr == 16'h03ba) || (hostIoAddr == 16'h03bf);
  assign videoIo = ((hostIoAddr >= 16'h03b0) && (hostIoAddr <= 16'h03bb)) ||
                   ((hostIoAddr >= 16'h03c0) && (hostIoAddr <= 16'h03df));
  assign monoOn = hostOpt[B_MONO_EN] && videoRouteEn;
  // Size code n covers 2^n megabytes; codes above 16 MB but below 8 never hit
  assign progMask = 12'((12'h001 << programmableVideoWindow[2:0]) - 12'h001);
  assign progHit = programmableVideoWindow[3] ||
                   ((programmableVideoWindow[2:0] <= PROG_SIZE_MAX[2:0]) &&
                    ((hostMemAddr[31:20] & ~progMask) ==
                     (programmableVideoWindow[15:4] & ~progMask)));

  // Routing and posting decisions, one clock after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      postHostWrite <= 1'b0;
      memToGraphics <= 1'b0;
      memToPrimary <= 1'b0;
      ioToGraphics <= 1'b0;
      ioToPrimary <= 1'b0;
    end else begin
      memToPrimary <= hostMemValid && monoOn && monoMem;
      memToGraphics <= hostMemValid && videoRouteEn && legacyMem &&
                       !(monoOn && monoMem);
      ioToPrimary <= hostIoValid && monoOn && monoIo;
      ioToGraphics <= hostIoValid && videoRouteEn && videoIo &&
                      !(monoOn && monoIo);
      // Mono ranges never post while monoOn: they leave for the primary bus
      postHostWrite <= hostMemValid && hostMemWrite && !(monoOn && monoMem) &&
                       ((fixedWindowEn && legacyMem) ||
                        (progWindowEn && progHit));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry latency
  // Select the field by where the cycle is headed
  always_ff @(posedge clk) begin
    if (srst) begin
      retryNow <= 1'b0;
    end else if (retryToHost) begin
      retryNow <= retryDue(retryCtl[1:0], retryFirstPhase, retryWaitClocks);
    end else begin
      retryNow <= retryDue(retryCtl[3:2], retryFirstPhase, retryWaitClocks);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter: 0 graphics master, 1 CPU, 2 port read/write, 3 primary writes
  gba_arb_t state;
  logic [1:0] owner; // Current or last owner, base of the rotation
  logic [1:0] pick;
  logic [7:0] sliceCnt, pickSlice; // Running slice and the slice of the next owner
  logic sliceRun; // Counting started: grant seen with the bus idle
  logic sliceDone, needFlush;
  logic flushMark; // Retried reader awaiting a flush
  assign pick = pickNext(busReq, owner);
  assign needFlush = arbOpt[B_FORCE_FLUSH] || (arbOpt[B_FLUSH_MODE] && flushMark);
  assign sliceDone = sliceRun && (sliceCnt == 8'h00);

  always_comb begin
    unique case (pick)
      2'd0: pickSlice = sliceClocks(gfxSlice);
      2'd1: pickSlice = sliceClocks(cpuSlice);
      2'd2: pickSlice = sliceClocks(portSlice);
      2'd3: pickSlice = sliceClocks(primSlice);
    endcase
  end

  // Mark a retried reader; a new retry in the grant cycle wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flushMark <= 1'b0;
    end else if (gfxReadRetried && arbOpt[B_FLUSH_MODE]) begin
      flushMark <= 1'b1;
    end else if (state == ARB_FLUSH && flushDone) begin
      flushMark <= 1'b0;
    end
  end

  // Grant sequencing; the owner is never preempted before its slice ends
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ARB_IDLE;
      owner <= 2'd3;
      busGrant <= 4'h0;
      flushReq <= 1'b0;
    end else begin
      unique case (state)
        ARB_IDLE: begin
          if (busReq != 4'h0) begin
            owner <= pick;
            if (pick == 2'd0 && needFlush) begin
              flushReq <= 1'b1;
              state <= ARB_FLUSH;
            end else begin
              busGrant <= 4'(4'h1 << pick);
              state <= ARB_OWN;
            end
          end
        end
        ARB_FLUSH: begin // Buffers drain before the graphics master sees its grant
          if (flushDone) begin
            flushReq <= 1'b0;
            busGrant <= 4'h1;
            state <= ARB_OWN;
          end
        end
        ARB_OWN: begin
          if (!busReq[owner] || (sliceDone && (busReq & ~busGrant) != 4'h0)) begin
            busGrant <= 4'h0;
            state <= ARB_IDLE;
          end
        end
        default: begin
          state <= ARB_IDLE;
          busGrant <= 4'h0;
          flushReq <= 1'b0;
        end
      endcase
    end
  end

  // Slice counter loads at grant and runs once the bus goes idle
  always_ff @(posedge clk) begin
    if (srst) begin
      sliceCnt <= 8'h00;
      sliceRun <= 1'b0;
    end else if (state != ARB_OWN) begin
      sliceCnt <= (state == ARB_FLUSH) ? sliceClocks(gfxSlice) : pickSlice;
      sliceRun <= 1'b0;
    end else if (!sliceRun) begin
      sliceRun <= busIdle;
    end else if (sliceCnt != 8'h00) begin
      sliceCnt <= 8'(sliceCnt - 8'h01);
    end
  end

  // Own request towards the graphics bus
  always_ff @(posedge clk) begin
    if (srst) begin
      hostBusRequest <= 1'b0;
    end else begin
      hostBusRequest <= arbOpt[B_FORCE_HOST_REQ] || hostWritePending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_pm_locked;
    cfgWrEn && !unlockCtrl && cfgAddr == OFS_CAP_ID |=> $stable(capId);
  endproperty
  a_pm_locked: assert property (p_pm_locked) else $error("locked capability id changed");
  property p_cap_read;
    cfgRdEn && cfgAddr == OFS_CAP_ID && !cfgWrEn |=> cfgRdData == $past(capId);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability id read wrong");
  property p_force_req;
    arbOpt[B_FORCE_HOST_REQ] |=> hostBusRequest;
  endproperty
  a_force_req: assert property (p_force_req) else $error("forced bus request dropped");
  property p_no_grant_flush;
    flushReq |-> busGrant == 4'h0;
  endproperty
  a_no_grant_flush: assert property (p_no_grant_flush) else $error("grant while flushing");
  property p_forced_flush;
    $rose(busGrant[0]) && $past(arbOpt[B_FORCE_FLUSH]) |-> $past(state) == ARB_FLUSH;
  endproperty
  a_forced_flush: assert property (p_forced_flush) else $error("grant without prior flush");
  property p_min_slice;
    state == ARB_OWN && !sliceDone && busReq[owner] |=> $stable(busGrant);
  endproperty
  a_min_slice: assert property (p_min_slice) else $error("grant lost before slice end");
  property p_slice_start;
    state == ARB_OWN && !sliceRun && !busIdle |=> !sliceRun;
  endproperty
  a_slice_start: assert property (p_slice_start) else $error("slice began on busy bus");
  property p_never_retry;
    retryToHost && retryCtl[1:0] == RETRY_NEVER |=> !retryNow;
  endproperty
  a_never_retry: assert property (p_never_retry) else $error("retry with never code");
  property p_mrm;
    memOpt[B_MRM_OFF] ##1 memOpt[B_MRM_OFF] |-> !mrmRecognize;
  endproperty
  a_mrm: assert property (p_mrm) else $error("read-multiple recognised while disabled");

endmodule

// ### verification/gba_requester_model.sv
////////////////////////////////////////////////////////////////////////
// Far side: graphics-bus masters and host requesters
module gba_requester_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] wantReq,
  input wire logic [3:0] idleLag,
  input wire logic [3:0] flushLag,
  input wire logic [3:0] busGrant,
  input wire logic flushReq,
  output logic [3:0] busReq,
  output logic busIdle,
  output logic flushDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idleCnt; // Cycles the new owner keeps the bus busy
  logic [3:0] flushCnt; // Cycles left until buffers are empty
  logic [3:0] lastGrant; // Grant seen one cycle ago
  logic newGrant; // Grant changed to a new owner this cycle

  // Requests come straight from the bench, which holds the owner's past its grant in the slice test
  assign busReq = wantReq;
  assign newGrant = (busGrant != lastGrant) && (busGrant != 4'h0);
  // Busy from the very first grant cycle, so a slice cannot start early
  assign busIdle = (idleCnt == 4'h0) && !newGrant;
  // Level answer, slow by flushLag cycles, gone once the request drops
  assign flushDone = flushReq && (flushCnt == 4'h0);

  // Turnaround and flush timers
  always_ff @(posedge clk) begin
    if (srst) begin
      idleCnt <= 4'h0;
      flushCnt <= 4'h0;
      lastGrant <= 4'h0;
    end else begin
      lastGrant <= busGrant;
      if (newGrant) begin
        idleCnt <= idleLag;
      end else if (idleCnt != 4'h0) begin
        idleCnt <= idleCnt - 4'h1;
      end
      if (!flushReq) begin
        flushCnt <= flushLag;
      end else if (flushCnt != 4'h0) begin
        flushCnt <= flushCnt - 4'h1;
      end
    end
  end
endmodule

// ### verification/gba_graphics_arbiter_tb_top.sv
////////////////////////////////////////////////////////////////////////
module gba_graphics_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gba_pkg::*;
  logic clk, srst, cfgWrEn, cfgRdEn, unlockCtrl, videoRouteEn, fixedWindowEn, progWindowEn;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData;
  logic [15:0] programmableVideoWindow, hostIoAddr;
  logic hostMemValid, hostMemWrite, hostIoValid, postHostWrite, memToGraphics, memToPrimary;
  logic [31:0] hostMemAddr;
  logic ioToGraphics, ioToPrimary, busIdle, gfxReadRetried, flushDone, hostWritePending;
  logic [3:0] busReq, busGrant, wantReq, idleLag, flushLag;
  logic flushReq, hostBusRequest, retryToHost, retryFirstPhase, retryNow, mrmRecognize;
  logic [5:0] retryWaitClocks;
  logic [1:0] prefetchLines, code;
  logic nbFrameCtrlEn, auxPowerNeeded, f;
  logic [6:0] t;
  int errors = 0;
  int checks = 0;
  int n;
  // Reset image, unmapped index 90h last
  logic [7:0] rOfs [14] = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f,
                            8'he0, 8'he1, 8'he2, 8'he3, 8'h90};
  logic [7:0] rVal [14] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20,
                            8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  // All-ones write and what may stick
  logic [7:0] wOfs [7] = '{8'h87, 8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h89};
  logic [7:0] wExp [7] = '{8'h60, 8'h8c, 8'h0f, 8'h83, 8'h00, 8'h00, 8'hff};
  logic [7:0] sOfs [4] = '{8'h89, 8'h8a, 8'h8e, 8'h8f};

  gba_graphics_arbiter u_gba_graphics_arbiter (
    .clk, .srst, .cfgAddr, .cfgWrEn, .cfgWrData, .cfgRdEn, .cfgRdData, .unlockCtrl,
    .videoRouteEn, .fixedWindowEn, .progWindowEn, .programmableVideoWindow, .hostMemValid,
    .hostMemWrite, .hostMemAddr, .hostIoValid, .hostIoAddr, .postHostWrite, .memToGraphics,
    .memToPrimary, .ioToGraphics, .ioToPrimary, .busReq, .busIdle, .gfxReadRetried,
    .flushDone, .hostWritePending, .busGrant, .flushReq, .hostBusRequest, .retryToHost,
    .retryFirstPhase, .retryWaitClocks, .retryNow, .mrmRecognize, .prefetchLines,
    .nbFrameCtrlEn, .auxPowerNeeded
  );
  gba_requester_model u_gba_requester_model (
    .clk, .srst, .wantReq, .idleLag, .flushLag, .busGrant, .flushReq, .busReq, .busIdle,
    .flushDone
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; a hang is far beyond the few hundred cycles used
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One config byte; the strobe drops at the next edge so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgAddr <= a;
    cfgWrData <= d;
    cfgWrEn <= 1'b1;
    @(posedge clk);
    cfgWrEn <= 1'b0;
  endtask
  // Read data is registered: looked at just after the edge that took the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfgAddr <= a;
    cfgRdEn <= 1'b1;
    @(posedge clk);
    cfgRdEn <= 1'b0;
    #1;
    chk("cfg", {8'h00, cfgRdData}, {8'h00, exp});
  endtask
  // One host access; routing flags are {post, memGfx, memPrim, ioGfx, ioPrim}
  task automatic dec(input logic io, input logic w, input logic [31:0] a, input logic [4:0] e);
    @(posedge clk);
    hostMemValid <= !io;
    hostIoValid <= io;
    hostMemWrite <= w;
    hostMemAddr <= a;
    hostIoAddr <= a[15:0];
    @(posedge clk);
    hostMemValid <= 1'b0;
    hostIoValid <= 1'b0;
    #1;
    chk("route", {11'h000, postHostWrite, memToGraphics, memToPrimary, ioToGraphics,
        ioToPrimary}, {11'h000, e});
  endtask
  task automatic rty(input logic h, input logic p, input logic [5:0] w, input logic e);
    @(posedge clk);
    retryToHost <= h;
    retryFirstPhase <= p;
    retryWaitClocks <= w;
    @(posedge clk);
    #1;
    chk("retry", {15'h0000, retryNow}, {15'h0000, e});
  endtask
  function automatic logic [6:0] thr(input logic [1:0] c, input logic first);
    case (c)
      2'b00: thr = first ? 7'h20 : 7'h08;
      2'b01: thr = first ? 7'h10 : 7'h04;
      2'b10: thr = 7'h02;
      default: thr = 7'h7f;
    endcase
  endfunction
  // Bounded wait for a grant; n returns the cycles spent
  task automatic waitGrant(input int i);
    n = 0;
    while (busGrant[i] !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Graphics master asks once; reports whether a flush came before its grant
  task automatic gfxReq(output logic sawFlush);
    sawFlush = 1'b0;
    @(posedge clk);
    wantReq <= 4'b0001;
    n = 0;
    while (busGrant[0] !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
      if (flushReq === 1'b1) sawFlush = 1'b1;
    end
    chk("gfx grant", {15'h0000, busGrant[0]}, 16'h0001);
    @(posedge clk);
    wantReq <= 4'b0000;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {cfgWrEn, cfgRdEn, unlockCtrl, videoRouteEn, fixedWindowEn, progWindowEn} = 6'h00;
    {cfgAddr, cfgWrData, programmableVideoWindow, hostIoAddr} = 48'h0;
    {hostMemValid, hostMemWrite, hostIoValid, gfxReadRetried, hostWritePending} = 5'h00;
    {hostMemAddr, retryToHost, retryFirstPhase, retryWaitClocks} = 40'h0;
    wantReq = 4'h0;
    idleLag = 4'h0;
    flushLag = 4'h3;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset", {nbFrameCtrlEn, mrmRecognize, prefetchLines, auxPowerNeeded}, 16'h1c);
    for (int i = 0; i < 14; i++) rd(rOfs[i], rVal[i]);
    for (int i = 0; i < 7; i++) wr(wOfs[i], 8'hff);
    for (int i = 0; i < 7; i++) rd(wOfs[i], wExp[i]);
    chk("opts", {hostBusRequest, nbFrameCtrlEn, mrmRecognize, prefetchLines}, 16'h0012);
    for (int i = 0; i < 7; i++) wr(wOfs[i], 8'h00);
    hostWritePending <= 1'b1;
    repeat (3) @(posedge clk);
    chk("opts", {hostBusRequest, nbFrameCtrlEn, mrmRecognize}, 16'h0007);
    hostWritePending <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      wr(OFS_MEM_OPT, 8'(i));
      repeat (2) @(negedge clk);
      chk("prefetch", {14'h0, prefetchLines}, (i == 2) ? 16'h3 : 16'h2);
    end
    // Capability bytes are locked until the bridge unlock is up
    wr(8'he0, 8'h55);
    wr(8'he2, 8'hff);
    rd(8'he0, 8'h01);
    rd(8'he2, 8'h00);
    @(posedge clk);
    unlockCtrl <= 1'b1;
    wr(8'he2, 8'hff);
    wr(8'he3, 8'hff);
    rd(8'he2, 8'h3f);
    rd(8'he3, 8'hfe);
    chk("aux", {15'h0, auxPowerNeeded}, 16'h0001);
    wr(8'he3, 8'h7e);
    repeat (2) @(negedge clk);
    chk("aux", {15'h0, auxPowerNeeded}, 16'h0000);
    // Address decode for the legacy and programmable windows
    fixedWindowEn <= 1'b1;
    dec(1'b0, 1'b1, 32'h000a0010, 5'b10000);
    dec(1'b0, 1'b1, 32'h000c0000, 5'b00000);
    @(posedge clk);
    fixedWindowEn <= 1'b0;
    videoRouteEn <= 1'b1;
    dec(1'b0, 1'b0, 32'h000a0000, 5'b01000);
    dec(1'b1, 1'b0, 32'h000003b6, 5'b00010);
    wr(OFS_HOST_OPT, 8'h40);
    dec(1'b0, 1'b0, 32'h000b0004, 5'b00100);
    dec(1'b1, 1'b0, 32'h000003b4, 5'b00001);
    dec(1'b1, 1'b0, 32'h000003bf, 5'b00001);
    wr(OFS_HOST_OPT, 8'h00);
    videoRouteEn <= 1'b0;
    progWindowEn <= 1'b1;
    programmableVideoWindow <= 16'h1001;
    dec(1'b0, 1'b1, 32'h101f0000, 5'b10000);
    dec(1'b0, 1'b1, 32'h10200000, 5'b00000);
    @(posedge clk);
    programmableVideoWindow <= 16'h0008;
    dec(1'b0, 1'b1, 32'h20000000, 5'b10000);
    @(posedge clk);
    progWindowEn <= 1'b0;
    // Retry thresholds: each field gets a different code
    for (int c = 0; c < 4; c++) begin
      code = 2'(c);
      wr(OFS_RETRY, {4'h0, code, ~code});
      for (int k = 0; k < 4; k++) begin
        t = thr(k[1] ? ~code : code, k[0]);
        if (t == 7'h7f) rty(k[1], k[0], 6'h3f, 1'b0);
        else begin
          rty(k[1], k[0], t[5:0], 1'b0);
          rty(k[1], k[0], t[5:0] + 6'h1, 1'b1);
        end
      end
    end
    // Each owner keeps the bus for its slice while a rival waits
    for (int i = 0; i < 4; i++) begin
      wr(sOfs[i], 8'h0b);
      @(posedge clk);
      idleLag <= 4'(5 + i);
      wantReq <= 4'b0001 << i;
      waitGrant(i);
      @(posedge clk);
      wantReq <= (4'b0001 << i) | (4'b0001 << ((i + 1) % 4));
      waitGrant(i);
      while (busGrant[i] === 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("slice", {15'h0, n >= 13 + i && n <= 17 + i}, 16'h1);
      waitGrant((i + 1) % 4);
      chk("next owner", {15'h0, n < 5}, 16'h1);
      @(posedge clk);
      wantReq <= 4'h0;
      repeat (4) @(posedge clk);
    end
    // Forced flush before every graphics grant, then the retried-reader mark
    wr(OFS_ARB_OPT, 8'h08);
    gfxReq(f);
    chk("forced flush", {15'h0, f}, 16'h1);
    gfxReq(f);
    chk("forced flush", {15'h0, f}, 16'h1);
    wr(OFS_ARB_OPT, 8'h80);
    @(posedge clk);
    gfxReadRetried <= 1'b1;
    @(posedge clk);
    gfxReadRetried <= 1'b0;
    gfxReq(f);
    chk("marked flush", {15'h0, f}, 16'h1);
    gfxReq(f);
    chk("unmarked", {15'h0, f}, 16'h0);
    test_done();
  end
endmodule
